// File: src/sbs_bridge.sv
/*
  Address latching, data steering and bus sizing between the processor local
  bus and the system, memory, on-board peripheral and slot buses.
  Assumes all bus inputs arrive from outside the clock domain on pins.
*/
`timescale 1ns/1ps
module sbs_bridge #(
  parameter int ADDR_W = sbs_pkg::ADDR_W,
  parameter int DATA_W = sbs_pkg::DATA_W,
  parameter int CTL_W  = sbs_pkg::CTL_W
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic [ADDR_W-1:0]   cpu_addr,
  input  wire logic [CTL_W-1:0]    cpu_ctl,
  input  wire logic                addr_strobe,
  input  wire logic                cycle_req,
  input  wire logic                cycle_write,
  input  wire logic                tgt_mem,
  input  wire logic                tgt_8bit,
  input  wire logic                tgt_onboard,
  input  wire logic [DATA_W-1:0]   cpu_data_in,
  input  wire logic                dma_active,
  input  wire logic [CTL_W-1:0]    dma_ctl_in,
  input  wire logic [sbs_pkg::XA_HI:1] onboard_peripheral_address_in,
  input  wire logic                byte_done,
  input  wire logic [DATA_W-1:0]   system_data_bus_in,
  input  wire logic [DATA_W-1:0]   memory_data_bus_in,
  input  wire logic [7:0]          onboard_peripheral_data_in,
  output logic [sbs_pkg::SA_HI:sbs_pkg::SA_LO] latched_system_address,
  output logic [CTL_W-1:0]         latched_ctl,
  output logic [sbs_pkg::LA_HI:sbs_pkg::LA_LO] early_unlatched_high_address,
  output logic [sbs_pkg::XA_HI:1]  onboard_peripheral_address_out,
  output logic                     onboard_peripheral_address_oe,
  output logic [sbs_pkg::DMA_A_HI:sbs_pkg::DMA_A_LO] dma_high_address,
  output logic [CTL_W-1:0]         dma_ctl_out,
  output logic [DATA_W-1:0]        cpu_data_out,
  output logic                     cpu_data_oe,
  output logic                     cpu_ready,
  output logic                     byte_phase_high,
  output logic [DATA_W-1:0]        system_data_bus_out,
  output logic                     system_data_bus_oe,
  output logic [DATA_W-1:0]        memory_data_bus_out,
  output logic                     memory_data_bus_oe,
  output logic [7:0]               onboard_peripheral_data_out,
  output logic                     onboard_peripheral_data_oe,
  output logic [DATA_W-1:8]        slot_high_data_out,
  output logic                     slot_high_data_oe
);
  localparam int BW = sbs_pkg::BYTE_W;

  // Two-stage synchronisers for every bus input; rst_n and ce are used directly
  localparam int SYN_W = ADDR_W + CTL_W + 7 + DATA_W + 1 + CTL_W + sbs_pkg::XA_HI
                       + DATA_W + DATA_W + BW;
  logic [SYN_W-1:0] sync1_r;
  logic [SYN_W-1:0] sync2_r;
  wire  [SYN_W-1:0] raw_in = {cpu_addr, cpu_ctl, addr_strobe, cycle_req, cycle_write,
                              tgt_mem, tgt_8bit, tgt_onboard, byte_done, cpu_data_in,
                              dma_active, dma_ctl_in, onboard_peripheral_address_in,
                              system_data_bus_in, memory_data_bus_in,
                              onboard_peripheral_data_in};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else if (ce) begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  wire [ADDR_W-1:0]         s_addr;
  wire [CTL_W-1:0]          s_ctl;
  wire                      s_as, s_req, s_wr, s_mem, s_8b, s_onb, s_bdone;
  wire [DATA_W-1:0]         s_cpu_d;
  wire                      s_dma;
  wire [CTL_W-1:0]          s_dma_ctl;
  wire [sbs_pkg::XA_HI:1]   s_xa;
  wire [DATA_W-1:0]         s_sd;
  wire [DATA_W-1:0]         s_md;
  wire [BW-1:0]             s_xd;
  assign {s_addr, s_ctl, s_as, s_req, s_wr, s_mem, s_8b, s_onb, s_bdone, s_cpu_d,
          s_dma, s_dma_ctl, s_xa, s_sd, s_md, s_xd} = sync2_r;

  // Request edge so one long request starts one transfer
  logic req_d_r;
  wire  req_rise = s_req & ~req_d_r;
  wire  split    = s_8b & ~s_mem;
  wire  in_b0, in_b1, fin;

  sbs_split_seq u_seq (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .start     (req_rise & split & ~s_dma),
    .byte_done (s_bdone),
    .in_byte0  (in_b0),
    .in_byte1  (in_b1),
    .finish    (fin)
  );

  // Source of the read data: peripheral byte lane, else system low and high byte lanes
  wire [BW-1:0] sys_lo_in  = s_onb ? s_xd : s_sd[BW-1:0];
  wire [BW-1:0] sys_hi_in  = s_onb ? s_xd : s_sd[DATA_W-1:BW];
  wire [BW-1:0] wr_byte    = in_b1 ? s_cpu_d[DATA_W-1:BW] : s_cpu_d[BW-1:0];
  wire          rd_active  = s_req & ~s_wr & ~s_dma;
  wire          wr_active  = s_req &  s_wr & ~s_dma;
  wire          direct_go  = req_rise & ~split & ~s_dma;

  logic [BW-1:0] low_latch_r;
  logic          direct_done_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_d_r       <= 1'b0;
      low_latch_r   <= sbs_pkg::BYTE_ZERO;
      direct_done_r <= 1'b0;
    end else if (ce) begin
      req_d_r       <= s_req;
      direct_done_r <= direct_go;
      if (in_b0 & s_bdone & ~s_wr)
        low_latch_r <= sys_lo_in;
      else if (fin)
        low_latch_r <= sbs_pkg::BYTE_ZERO;
    end
  end

  // Address path: latched group, early group, peripheral address, DMA group
  logic [sbs_pkg::SA_HI:sbs_pkg::SA_LO] sa_nxt;
  logic [sbs_pkg::XA_HI:1]  xa_nxt;
  assign sa_nxt = s_dma ? {s_addr[sbs_pkg::SA_HI:sbs_pkg::XA_HI+1], s_xa}
                        : s_addr[sbs_pkg::SA_HI:sbs_pkg::SA_LO];
  assign xa_nxt = latched_system_address[sbs_pkg::XA_HI:1];

  // Data outputs, decoded combinationally then registered
  logic [DATA_W-1:0] cpu_d_nxt;
  logic [DATA_W-1:0] sd_nxt;
  logic              sd_oe_nxt;
  logic              md_oe_nxt;
  logic [BW-1:0]     xd_nxt;
  logic              xd_oe_nxt;
  assign cpu_d_nxt = split ? {sys_hi_in, low_latch_r}
                           : (s_mem ? s_md : s_sd);
  assign sd_nxt    = split ? {wr_byte, wr_byte} : s_cpu_d;
  assign sd_oe_nxt = wr_active & (~split | in_b0 | in_b1);
  assign md_oe_nxt = wr_active & s_mem;
  assign xd_nxt    = split ? wr_byte : s_cpu_d[BW-1:0];
  assign xd_oe_nxt = wr_active & s_onb & ~s_mem & (~split | in_b0 | in_b1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latched_system_address         <= '0;
      latched_ctl                    <= '0;
      early_unlatched_high_address   <= '0;
      onboard_peripheral_address_out <= '0;
      onboard_peripheral_address_oe  <= 1'b0;
      dma_high_address               <= '0;
      dma_ctl_out                    <= '0;
      cpu_data_out                   <= '0;
      cpu_data_oe                    <= 1'b0;
      cpu_ready                      <= 1'b0;
      byte_phase_high                <= 1'b0;
      system_data_bus_out            <= '0;
      system_data_bus_oe             <= 1'b0;
      memory_data_bus_out            <= '0;
      memory_data_bus_oe             <= 1'b0;
      onboard_peripheral_data_out    <= sbs_pkg::BYTE_ZERO;
      onboard_peripheral_data_oe     <= 1'b0;
      slot_high_data_out             <= '0;
      slot_high_data_oe              <= 1'b0;
    end else if (ce) begin
      if (s_as | s_dma) begin
        latched_system_address <= sa_nxt;
        latched_ctl            <= s_dma ? s_dma_ctl : s_ctl;
      end
      early_unlatched_high_address   <= s_addr[sbs_pkg::LA_HI:sbs_pkg::LA_LO];
      onboard_peripheral_address_out <= xa_nxt;
      onboard_peripheral_address_oe  <= ~s_dma;
      dma_high_address <= s_addr[sbs_pkg::DMA_A_HI:sbs_pkg::DMA_A_LO];
      dma_ctl_out      <= s_dma_ctl;
      cpu_data_out     <= cpu_d_nxt;
      cpu_data_oe      <= rd_active & (split ? (in_b1 & s_bdone) : 1'b1);
      cpu_ready        <= split ? (in_b1 & s_bdone) : direct_done_r;
      byte_phase_high  <= in_b1;
      system_data_bus_out <= sd_nxt;
      system_data_bus_oe  <= sd_oe_nxt;
      // Memory side sees what this block puts on the system data bus
      memory_data_bus_out <= sd_nxt;
      memory_data_bus_oe  <= md_oe_nxt;
      onboard_peripheral_data_out <= xd_nxt;
      onboard_peripheral_data_oe  <= xd_oe_nxt;
      // One set of lines fans out to every slot
      slot_high_data_out <= sd_nxt[DATA_W-1:BW];
      slot_high_data_oe  <= wr_active & ~split & ~s_mem & ~s_onb;
    end
  end
endmodule // sbs_bridge

// File: src/sbs_pkg.sv
/*
  Shared widths, field positions and state codes for the bus sizing buffer.
  Assumes a single 25 MHz clock domain and no software-visible registers.
*/
package sbs_pkg;
  localparam int          ADDR_W      = 24;
  localparam int          DATA_W      = 16;
  localparam int          BYTE_W      = 8;
  localparam int          SA_LO       = 1;
  localparam int          SA_HI       = 19;
  localparam int          LA_LO       = 17;
  localparam int          LA_HI       = 23;
  localparam int          XA_HI       = 16;
  localparam int          DMA_A_LO    = 17;
  localparam int          DMA_A_HI    = 19;
  localparam int          CTL_W       = 4;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;

  // Split-transfer sequencer, one-hot
  typedef enum logic [3:0] {
    SBS_IDLE   = 4'h1,
    SBS_BYTE0  = 4'h2,
    SBS_BYTE1  = 4'h4,
    SBS_DONE   = 4'h8
  } sbs_state_e;
endpackage

// File: src/sbs_split_seq.sv
/*
  Split-transfer sequencer: runs two byte cycles for a word to an 8-bit target.
  Assumes requests come from same-clock logic and the bus answers with byte_done.
*/
`timescale 1ns/1ps
module sbs_split_seq (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic start,
  input  wire logic byte_done,
  output logic      in_byte0,
  output logic      in_byte1,
  output logic      finish
);
  sbs_pkg::sbs_state_e state_r;
  sbs_pkg::sbs_state_e state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sbs_pkg::SBS_IDLE:  if (start) state_nxt = sbs_pkg::SBS_BYTE0;
      sbs_pkg::SBS_BYTE0: if (byte_done) state_nxt = sbs_pkg::SBS_BYTE1;
      sbs_pkg::SBS_BYTE1: if (byte_done) state_nxt = sbs_pkg::SBS_DONE;
      sbs_pkg::SBS_DONE:  state_nxt = sbs_pkg::SBS_IDLE;
      default:            state_nxt = sbs_pkg::SBS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) state_r <= sbs_pkg::SBS_IDLE;
    else if (ce) state_r <= state_nxt;
  end

  assign in_byte0 = (state_r == sbs_pkg::SBS_BYTE0);
  assign in_byte1 = (state_r == sbs_pkg::SBS_BYTE1);
  assign finish   = (state_r == sbs_pkg::SBS_DONE);
endmodule // sbs_split_seq

// File: tb/sbs_bridge_sva.sv
/* Port timing checker for sbs_bridge.
   Assumes one clock, synchronous low reset, bound below. */
`timescale 1ns/1ps
module sbs_bridge_sva (
  input wire logic         clk,
  input wire logic         rst_n,
  input wire logic [23:0]  cpu_addr,
  input wire logic [3:0]   cpu_ctl,
  input wire logic         addr_strobe,
  input wire logic         cycle_req,
  input wire logic         tgt_mem,
  input wire logic         tgt_8bit,
  input wire logic         dma_active,
  input wire logic [3:0]   dma_ctl_in,
  input wire logic [19:1]  latched_system_address,
  input wire logic [3:0]   latched_ctl,
  input wire logic [23:17] early_unlatched_high_address,
  input wire logic         onboard_peripheral_address_oe,
  input wire logic [3:0]   dma_ctl_out,
  input wire logic         cpu_ready,
  input wire logic         byte_phase_high,
  input wire logic [15:0]  system_data_bus_out,
  input wire logic [15:8]  slot_high_data_out,
  input wire logic         slot_high_data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_req; $rose(cycle_req) && !dma_active; endsequence
  sequence s_split; s_req ##0 (tgt_8bit && !tgt_mem); endsequence
  sequence s_direct; s_req ##0 !(tgt_8bit && !tgt_mem); endsequence
  a_ready_pulse: assert property (cpu_ready |=> !cpu_ready)
    else $error("ready longer than one cycle");
  a_direct_ready: assert property (s_direct |-> ##[2:8] cpu_ready)
    else $error("direct cycle not answered");
  a_split_phase: assert property (s_split |-> ##[3:40] byte_phase_high)
    else $error("split cycle never reached high byte");
  a_split_wait: assert property (s_split |=> !cpu_ready [*4])
    else $error("split cycle answered too early");
  a_early_addr: assert property ($stable(cpu_addr) [*5] |->
    early_unlatched_high_address == cpu_addr[23:17])
    else $error("early address wrong");
  a_latch_addr: assert property ((addr_strobe && !dma_active && $stable(cpu_addr)
    && $stable(cpu_ctl)) [*5] |-> latched_system_address == cpu_addr[19:1]
    && latched_ctl == cpu_ctl)
    else $error("latched address or control wrong");
  a_dma_dir: assert property (dma_active [*5] |-> !onboard_peripheral_address_oe)
    else $error("address buffer drives under dma");
  a_dma_ctl: assert property ((dma_active && $stable(dma_ctl_in)) [*5] |->
    dma_ctl_out == dma_ctl_in)
    else $error("dma control not buffered");
  a_slot_high: assert property (slot_high_data_oe |->
    slot_high_data_out == system_data_bus_out[15:8])
    else $error("slot high byte differs");
endmodule // sbs_bridge_sva
bind sbs_bridge sbs_bridge_sva i_sva (.*);

// File: tb/sbs_periph_model.sv
/* Eight-bit peripheral answering byte cycles.
   Assumes busy marks an open cycle and gap is above zero. */
`timescale 1ns/1ps
module sbs_periph_model (
  input  wire logic       clk,
  input  wire logic       busy,
  input  wire logic       hi_ph,
  input  wire logic [3:0] gap,
  input  wire logic [7:0] lo,
  input  wire logic [7:0] hi,
  output logic            done,
  output logic [7:0]      xd
);
  logic [3:0] cnt_r;
  always_ff @(posedge clk) begin
    cnt_r <= (!busy || cnt_r == gap) ? 4'h0 : cnt_r + 4'h1;
  end
  assign done = busy && cnt_r == gap;
  // Released bus shows inverted data, never a stale byte
  assign xd = !busy ? ~lo : (hi_ph ? hi : lo);
endmodule // sbs_periph_model

// File: tb/test_system_bus_sizing_buffer.sv
/* Self-checking bench for sbs_bridge with a peripheral model.
   Assumes 25 MHz clock; inputs change on falling edges. */
`timescale 1ns/1ps
module test_system_bus_sizing_buffer;
  logic clk, rst_n, ce, addr_strobe, cycle_req, cycle_write, tgt_mem, tgt_8bit, tgt_onboard;
  logic dma_active, byte_done, onboard_peripheral_address_oe, cpu_data_oe, cpu_ready;
  logic byte_phase_high, system_data_bus_oe, memory_data_bus_oe, onboard_peripheral_data_oe;
  logic slot_high_data_oe;
  logic [23:0] cpu_addr, a;
  logic [3:0]  cpu_ctl, dma_ctl_in, latched_ctl, dma_ctl_out, gap;
  logic [16:1] onboard_peripheral_address_in, onboard_peripheral_address_out;
  logic [15:0] cpu_data_in, system_data_bus_in, memory_data_bus_in, cpu_data_out, rd, sd, md;
  logic [15:0] system_data_bus_out, memory_data_bus_out;
  logic [7:0]  onboard_peripheral_data_in, onboard_peripheral_data_out, lo, hi, xlo, xhi, sh;
  logic [3:0]  oes;
  logic [19:1] latched_system_address;
  logic [23:17] early_unlatched_high_address;
  logic [19:17] dma_high_address;
  logic [15:8] slot_high_data_out;
  int n_fail, num_checks, cyc, n_rdy;
  sbs_bridge i_dut (.*);
  sbs_periph_model i_far (.clk(clk), .busy(cycle_req && tgt_8bit), .hi_ph(byte_phase_high),
    .gap(gap), .lo(lo), .hi(hi), .done(byte_done), .xd(onboard_peripheral_data_in));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // Whole run needs about 550 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held long past the answer so a second answer would show
  task automatic run(logic wr, m, b8, logic [15:0] d);
    n_rdy = 0;
    @(negedge clk);
    {cycle_write, tgt_mem, tgt_8bit, tgt_onboard, cpu_data_in} = {wr, m, b8, b8, d};
    cycle_req = 1;
    repeat (60) begin
      @(negedge clk);
      if (onboard_peripheral_data_oe === 1'b1 && byte_phase_high === 1'b1)
        xhi = onboard_peripheral_data_out;
      else if (onboard_peripheral_data_oe === 1'b1)
        xlo = onboard_peripheral_data_out;
      if (cpu_ready === 1'b1 && n_rdy == 0) begin
        {rd, sd, md, sh} = {cpu_data_out, system_data_bus_out,
                            memory_data_bus_out, slot_high_data_out};
        oes = {cpu_data_oe, system_data_bus_oe, memory_data_bus_oe, slot_high_data_oe};
      end
      if (cpu_ready === 1'b1) n_rdy++;
    end
    cycle_req = 0;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_addr();
    {cpu_addr, cpu_ctl, addr_strobe} = {24'ha5c3e6, 4'h9, 1'b1};
    a = cpu_addr;
    repeat (6) @(negedge clk);
    addr_strobe = 0;
    chk("sa", a[19:1], latched_system_address);
    chk("ctl", 4'h9, latched_ctl);
    chk("xa", a[16:1], onboard_peripheral_address_out);
    chk("xa_oe", 1'b1, onboard_peripheral_address_oe);
    cpu_addr = 24'h3a5018;
    repeat (6) @(negedge clk);
    chk("sa_hold", a[19:1], latched_system_address);
    chk("la", 7'h1d, early_unlatched_high_address);
    $display("test addr done");
  endtask
  task automatic t_dma();
    {dma_active, dma_ctl_in, onboard_peripheral_address_in} = {1'b1, 4'h6, 16'hb2c4};
    cpu_addr = 24'h0a0000;
    repeat (6) @(negedge clk);
    chk("xa_oe_dma", 1'b0, onboard_peripheral_address_oe);
    chk("sa_dma", 16'hb2c4, latched_system_address[16:1]);
    chk("dma_hi", 3'h5, dma_high_address);
    chk("dma_ctl", 4'h6, dma_ctl_out);
    run(0, 0, 1, 16'h0000);
    chk("dma_refused", 0, n_rdy);
    dma_active = 0;
    repeat (6) @(negedge clk);
    $display("test dma done");
  endtask
  task automatic t_split();
    {gap, lo, hi} = {4'h3, 8'h3c, 8'hd5};
    run(0, 0, 1, 16'h0000);
    chk("split_rd", 16'hd53c, rd);
    chk("split_n", 1, n_rdy);
    chk("split_rd_oe", 4'h8, oes);
    {gap, lo, hi} = {4'h9, 8'h81, 8'h7e};
    run(0, 0, 1, 16'h0000);
    chk("slow_rd", 16'h7e81, rd);
    run(1, 0, 1, 16'h96e4);
    chk("wr_lo", 8'he4, xlo);
    chk("wr_hi", 8'h96, xhi);
    chk("wr_n", 1, n_rdy);
    chk("split_wr_oe", 4'h4, oes);
    $display("test split done");
  endtask
  task automatic t_direct();
    {memory_data_bus_in, system_data_bus_in} = {16'h5aa5, 16'he00f};
    run(0, 1, 0, 16'h0000);
    chk("mem_rd", 16'h5aa5, rd);
    chk("mem_rd_oe", 4'h8, oes);
    run(1, 1, 0, 16'hc3e1);
    chk("mem_wr", 16'hc3e1, md);
    chk("mem_wr_oe", 4'h6, oes);
    run(0, 0, 0, 16'h0000);
    chk("slot_rd", 16'he00f, rd);
    chk("slot_rd_oe", 4'h8, oes);
    run(1, 0, 0, 16'h7b18);
    chk("slot_wr", 16'h7b18, sd);
    chk("slot_wr_oe", 4'h5, oes);
    chk("slot_hi", 8'h7b, sh);
    $display("test direct done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    {addr_strobe, cycle_req, cycle_write, tgt_mem, tgt_8bit, tgt_onboard, dma_active} = '0;
    {cpu_addr, cpu_ctl, dma_ctl_in, onboard_peripheral_address_in, cpu_data_in} = '0;
    {system_data_bus_in, memory_data_bus_in, gap, lo, hi} = {32'h0, 4'h3, 16'h0};
    {rst_n, ce} = 2'b01;
    repeat (3) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    t_addr();
    t_dma();
    t_split();
    t_direct();
    report_and_stop();
  end
endmodule // test_system_bus_sizing_buffer
